// ==== src/dim_pkg.sv ====
// Constants, register map and carrier types of the door intrusion monitor.
// Assumes a 50 MHz system clock and an APB register bus with 32-bit data.
package dim_pkg;

  // Timing
  localparam int unsigned SYS_CLK_HZ       = 50_000_000;
  localparam int unsigned TICK_PERIOD_S    = 1;
  localparam int unsigned TICK_CYCLES_DFLT = TICK_PERIOD_S * SYS_CLK_HZ;
  localparam int unsigned PRE_W            = 26;

  // Adjustable periods, seconds
  localparam logic [6:0] ENTRY_MIN_S = 7'h0F;
  localparam logic [6:0] ENTRY_MAX_S = 7'h1E;
  localparam logic [6:0] ALARM_MIN_S = 7'h1E;
  localparam logic [6:0] ALARM_MAX_S = 7'h78;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;
  localparam logic [11:0] EVENT_OFS    = 12'h010;

  // Control fields and reset values
  localparam int unsigned CTRL_ENTRY_LSB = 0;
  localparam int unsigned CTRL_ALARM_LSB = 8;
  localparam int unsigned CTRL_OOS_BIT   = 16;
  localparam logic [4:0]  ENTRY_RST      = 5'h0F;
  localparam logic [6:0]  ALARM_RST      = 7'h1E;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

  // Event bits, shared by irq status, mask and last event code
  localparam int unsigned EV_FRONT_AUTH   = 0;
  localparam int unsigned EV_FRONT_UNAUTH = 1;
  localparam int unsigned EV_INT_AUTH     = 2;
  localparam int unsigned EV_INT_UNAUTH   = 3;

  // Access sequence steps
  localparam logic [2:0] STEP_NONE    = 3'h0;
  localparam logic [2:0] STEP_LOCK    = 3'h1;
  localparam logic [2:0] STEP_LATCH   = 3'h2;
  localparam logic [2:0] STEP_OPENED  = 3'h3;
  localparam logic [2:0] STEP_SHUNTED = 3'h4;
  localparam logic [2:0] STEP_CODE    = 3'h5;

  // Synchronised pin bit positions
  localparam int unsigned SYNC_W     = 6;
  localparam int unsigned PIN_FRONT  = 0;
  localparam int unsigned PIN_SHUNT  = 1;
  localparam int unsigned PIN_LOCK   = 2;
  localparam int unsigned PIN_LATCH  = 3;
  localparam int unsigned PIN_INT    = 4;
  localparam int unsigned PIN_KEYPAD = 5;

  typedef enum logic [1:0] {
    F_IDLE    = 2'b00,
    F_DELAY   = 2'b01,
    F_ALARM   = 2'b11,
    F_SHUNTED = 2'b10
  } dim_front_t;

  typedef enum logic [1:0] {
    I_IDLE  = 2'b00,
    I_OK    = 2'b01,
    I_ALARM = 2'b11
  } dim_int_t;

  typedef struct packed {
    logic interior;
    logic intrusion;
    logic not_in_service;
    logic door_open;
  } dim_report_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } dim_sync_t;

  typedef struct packed {
    logic [6:0] cnt;
  } dim_tmr_t;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    dim_front_t       fst;
    dim_int_t         ist;
    logic [2:0]       step;
    logic [6:0]       fdur;
    logic [4:0]       cfg_entry;
    logic [6:0]       cfg_alarm;
    logic             oos;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic [3:0]       last_code;
    logic [7:0]       evt_cnt;
    logic             int_pend;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             rep_valid;
    dim_report_t      rep;
    logic [SYNC_W-1:0] prev;
  } dim_state_t;

endpackage

// ==== src/dim_sync.sv ====
// Two-flop synchroniser for the door, key and keypad pins.
// Assumes asynchronous pins; only the second stage is read outside.
`timescale 1ns/100ps
module dim_sync (
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic [dim_pkg::SYNC_W-1:0] pin_in,
  output logic      [dim_pkg::SYNC_W-1:0] pin_sync
);
  import dim_pkg::*;

  dim_sync_t q;
  dim_sync_t d;

  always_comb begin
    d    = q;
    d.s1 = pin_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_sync = q.s2;
endmodule

// ==== src/dim_timer.sv ====
// Seconds countdown timer, loaded with a period and stepped by a 1 s tick.
// Assumes load and tick come from logic on sys_clk; load wins over tick.
`timescale 1ns/100ps
module dim_timer (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       load,
  input  wire logic [6:0] load_val,
  input  wire logic       tick,
  output logic            expired
);
  import dim_pkg::*;

  dim_tmr_t q;
  dim_tmr_t d;

  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
    end else if (tick && q.cnt != 7'h00) begin
      d.cnt = q.cnt - 7'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = (q.cnt == 7'h00);
endmodule

// ==== src/dim_top.sv ====
// Door and intrusion monitor: front door entry delay, shunt key, interior
// door access sequence, local alarm, event reports and APB registers.
// Assumes door, key and keypad signals are raw pins; the keypad pin rises
// once for each accepted identification code.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps

// Functional notes
// R1 - Front opening starts 15-30 s entry delay; alarm sounds only after it expires.
// R2 - Shunt key operated after the door opened silences the front alarm.
// R3 - Shunt within delay: authorised, recorded, reported out of service with door-open code.
// R4 - Delay expired unshunted: unauthorised, recorded, intrusion reported, local alarm.
// R5 - Unauthorised alarm lasts 30 s-2 min, then clears once door closed.
// R6 - Interior opening alarms unless lock, latch, open, shunt, code came in order.
// R7 - Keypad identification code acts as the interior door shunt.
// R8 - Interior openings classified, recorded, reported like front; alarm when unauthorised.
// R9 - Fare processing stops while the remote centre holds the unit out of service.
// R10 - Periods sampled at each opening; each opening gives exactly one event (a reopening during F_ALARM or I_ALARM gives none).
module dim_top #(
  parameter int unsigned TICK_CYCLES = dim_pkg::TICK_CYCLES_DFLT
) (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Pins
  input  wire logic                 front_open_pin,
  input  wire logic                 shunt_key_pin,
  input  wire logic                 lock_release_pin,
  input  wire logic                 latch_retract_pin,
  input  wire logic                 interior_open_pin,
  input  wire logic                 keypad_code_pin,
  // Outputs
  output logic                      audible_alarm,
  output logic                      fare_enable,
  output logic                      report_valid,
  output dim_pkg::dim_report_t      report,
  output logic                      irq
);
  import dim_pkg::*;

  function automatic logic [6:0] clamp7(input logic [6:0] v,
                                        input logic [6:0] lo,
                                        input logic [6:0] hi);
    logic [6:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic rose(input logic [SYNC_W-1:0] now,
                                input logic [SYNC_W-1:0] was,
                                input int unsigned      bit_i);
    return now[bit_i] && !was[bit_i];
  endfunction

  dim_state_t        q;
  dim_state_t        d;
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sy;
  logic              tick;
  logic              f_load;
  logic [6:0]        f_load_val;
  logic              f_expired;
  logic              i_load;
  logic [6:0]        i_load_val;
  logic              i_expired;
  logic              front_open;
  logic              int_open;
  logic              shunt_rise;
  logic              front_rise;
  logic              int_rise;
  logic              key_rise;
  logic              lock_rise;
  logic              latch_rise;
  logic              setup_ph;
  logic              wr_acc;
  logic [3:0]        ev;
  logic [31:0]       rd_val;
  logic              mapped;

  assign pins = {keypad_code_pin, interior_open_pin, latch_retract_pin,
                 lock_release_pin, shunt_key_pin, front_open_pin};

  dim_sync u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .pin_in   (pins),
    .pin_sync (sy)
  );

  dim_timer u_front_tmr (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .load     (f_load),
    .load_val (f_load_val),
    .tick     (tick),
    .expired  (f_expired)
  );

  dim_timer u_int_tmr (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .load     (i_load),
    .load_val (i_load_val),
    .tick     (tick),
    .expired  (i_expired)
  );

  assign tick       = (q.pre == PRE_W'(TICK_CYCLES - 1));
  assign front_open = sy[PIN_FRONT];
  assign int_open   = sy[PIN_INT];
  assign front_rise = rose(sy, q.prev, PIN_FRONT);
  assign shunt_rise = rose(sy, q.prev, PIN_SHUNT);
  assign lock_rise  = rose(sy, q.prev, PIN_LOCK);
  assign latch_rise = rose(sy, q.prev, PIN_LATCH);
  assign int_rise   = rose(sy, q.prev, PIN_INT);
  assign key_rise   = rose(sy, q.prev, PIN_KEYPAD);
  assign setup_ph   = psel && !penable;
  assign wr_acc     = psel && penable && pwrite;

  // Read mux and decode
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      CTRL_OFS: begin
        rd_val[CTRL_ENTRY_LSB +: 5] = q.cfg_entry;
        rd_val[CTRL_ALARM_LSB +: 7] = q.cfg_alarm;
        rd_val[CTRL_OOS_BIT]        = q.oos;
      end
      STATUS_OFS: begin
        rd_val[SYNC_W-1:0] = sy;
        rd_val[10:8]       = q.step;
        rd_val[13:12]      = q.fst;
        rd_val[15:14]      = q.ist;
        rd_val[16]         = audible_alarm;
      end
      IRQ_STAT_OFS: rd_val[3:0] = q.irq_stat;
      IRQ_MASK_OFS: rd_val[3:0] = q.irq_mask;
      EVENT_OFS: begin
        rd_val[3:0]  = q.last_code;
        rd_val[15:8] = q.evt_cnt;
      end
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    d          = q;
    ev         = 4'h0;
    f_load     = 1'b0;
    f_load_val = q.fdur;
    i_load     = 1'b0;
    i_load_val = clamp7(q.cfg_alarm, ALARM_MIN_S, ALARM_MAX_S);
    d.prev     = sy;
    d.pre      = tick ? '0 : q.pre + PRE_W'(1);
    d.rep_valid = 1'b0;

    // Front door or primary cover
    case (q.fst)
      F_IDLE: begin
        if (front_rise) begin
          d.fst      = F_DELAY;
          f_load     = 1'b1; // R1
          f_load_val = clamp7({2'b00, q.cfg_entry}, ENTRY_MIN_S, ENTRY_MAX_S); // R10
          d.fdur     = clamp7(q.cfg_alarm, ALARM_MIN_S, ALARM_MAX_S); // R10
        end
      end
      F_DELAY: begin
        if (shunt_rise) begin
          d.fst = F_SHUNTED; // R2
          ev[EV_FRONT_AUTH] = 1'b1; // R3
        end else if (!front_open) begin
          // Closed unshunted: still one event, but no local alarm
          d.fst = F_IDLE;
          ev[EV_FRONT_UNAUTH] = 1'b1; // R10
        end else if (f_expired) begin
          d.fst  = F_ALARM; // R1
          f_load = 1'b1; // R5
          ev[EV_FRONT_UNAUTH] = 1'b1; // R4
        end
      end
      F_ALARM: begin
        if (shunt_rise) begin
          d.fst = F_SHUNTED; // R2
        end else if (f_expired && !front_open) begin
          d.fst = F_IDLE; // R5
        end
      end
      F_SHUNTED: begin
        if (!front_open) begin
          d.fst = F_IDLE;
        end
      end
      default: d.fst = F_IDLE;
    endcase

    // Access sequence toward the interior door
    if (lock_rise) begin
      d.step = STEP_LOCK; // R6
    end else if (latch_rise) begin
      d.step = (q.step == STEP_LOCK) ? STEP_LATCH : STEP_NONE; // R6
    end else if (front_rise && q.step == STEP_LATCH) begin
      d.step = STEP_OPENED; // R6
    end else if (q.fst == F_DELAY && d.fst == F_SHUNTED) begin
      d.step = (q.step == STEP_OPENED) ? STEP_SHUNTED : STEP_NONE; // R6
    end else if (key_rise) begin
      d.step = (q.step == STEP_SHUNTED) ? STEP_CODE : STEP_NONE; // R7
    end
    if (!front_open && q.step >= STEP_OPENED) begin
      d.step = STEP_NONE;
    end

    // Interior money-area door
    case (q.ist)
      I_IDLE: begin
        if (int_rise) begin
          if (q.step == STEP_CODE) begin
            d.ist = I_OK; // R7
            ev[EV_INT_AUTH] = 1'b1; // R8
          end else begin
            d.ist  = I_ALARM; // R6
            i_load = 1'b1; // R10
            ev[EV_INT_UNAUTH] = 1'b1; // R8
          end
        end
      end
      I_OK: begin
        if (!int_open) begin
          d.ist = I_IDLE;
        end
      end
      I_ALARM: begin
        if (i_expired && !int_open) begin
          d.ist = I_IDLE; // R5
        end
      end
      default: d.ist = I_IDLE;
    endcase

    // Recording and reporting; front goes first, interior waits a cycle
    if (ev[EV_FRONT_AUTH] || ev[EV_FRONT_UNAUTH]) begin
      d.rep_valid          = 1'b1;
      d.rep.interior       = 1'b0;
      d.rep.intrusion      = ev[EV_FRONT_UNAUTH]; // R4
      d.rep.not_in_service = ev[EV_FRONT_AUTH]; // R3
      d.rep.door_open      = ev[EV_FRONT_AUTH]; // R3
      d.last_code          = ev & 4'h3;
      d.evt_cnt            = q.evt_cnt + 8'h01;
      d.int_pend           = ev[EV_INT_AUTH] || ev[EV_INT_UNAUTH];
    end else if (q.int_pend || ev[EV_INT_AUTH] || ev[EV_INT_UNAUTH]) begin
      d.rep_valid          = 1'b1;
      d.rep.interior       = 1'b1;
      d.rep.intrusion      = q.int_pend ? q.last_code[EV_INT_UNAUTH]
                                        : ev[EV_INT_UNAUTH]; // R8
      d.rep.not_in_service = !d.rep.intrusion; // R8
      d.rep.door_open      = !d.rep.intrusion; // R8
      d.last_code          = q.int_pend ? (q.last_code & 4'hC) : (ev & 4'hC);
      d.evt_cnt            = q.evt_cnt + 8'h01;
      d.int_pend           = 1'b0;
    end
    // Park the pending interior code beside the front code
    if (d.int_pend) begin
      d.last_code = d.last_code | (ev & 4'hC);
    end

    // APB: read data and error latched in setup, writes take effect in access
    if (setup_ph) begin
      d.prdata  = rd_val;
      d.pslverr = !mapped;
    end
    if (wr_acc && mapped) begin
      case (paddr)
        CTRL_OFS: begin
          d.cfg_entry = pwdata[CTRL_ENTRY_LSB +: 5];
          d.cfg_alarm = pwdata[CTRL_ALARM_LSB +: 7];
          d.oos       = pwdata[CTRL_OOS_BIT]; // R9
        end
        IRQ_MASK_OFS: d.irq_mask = pwdata[3:0];
        default: d.irq_mask = q.irq_mask;
      endcase
    end

    // Sticky status: a new event wins over a write-one clear
    d.irq_stat = q.irq_stat;
    if (wr_acc && paddr == IRQ_STAT_OFS) begin
      d.irq_stat = q.irq_stat & ~pwdata[3:0];
    end
    d.irq_stat = d.irq_stat | ev;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q           <= '0;
      q.fst       <= F_IDLE;
      q.ist       <= I_IDLE;
      q.cfg_entry <= ENTRY_RST;
      q.cfg_alarm <= ALARM_RST;
      q.fdur      <= ALARM_RST;
      q.irq_mask  <= IRQ_MASK_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata        = q.prdata;
  assign pslverr       = q.pslverr && psel && penable;
  assign pready        = 1'b1;
  assign audible_alarm = (q.fst == F_ALARM) || (q.ist == I_ALARM); // R4
  assign fare_enable   = !q.oos; // R9
  assign report_valid  = q.rep_valid;
  assign report        = q.rep;
  assign irq           = |(q.irq_stat & q.irq_mask);
endmodule

// ==== sim/dim_top_sva.sv ====
// Concurrent checks on the door intrusion monitor, from dim_top ports only.
// Assumes one sys_clk domain; bound into dim_top by the bench top file.
`timescale 1ns/100ps
module dim_top_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic                 sys_clk,
  input wire logic                 resetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 front_open_pin,
  input wire logic                 interior_open_pin,
  input wire logic                 audible_alarm,
  input wire logic                 fare_enable,
  input wire logic                 report_valid,
  input wire dim_pkg::dim_report_t report
);
  import dim_pkg::*;
  // Free-running tick may fire up to one tick early
  localparam int unsigned ENTRY_LOW = (int'(ENTRY_MIN_S) - 1) * TICK_CYCLES;
  localparam int unsigned ALARM_LOW = (int'(ALARM_MIN_S) - 1) * TICK_CYCLES;
  logic        fo_q;
  int unsigned since_q;
  int unsigned on_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fo_q    <= 1'b0;
      since_q <= 0;
      on_q    <= 0;
    end else begin
      fo_q    <= front_open_pin;
      since_q <= (front_open_pin && !fo_q) ? 0 : since_q + 1;
      on_q    <= audible_alarm ? on_q + 1 : 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_entry_quiet: assert property (
    $rose(audible_alarm) |-> interior_open_pin || since_q >= ENTRY_LOW)
    else $error("alarm before entry delay");
  a_alarm_report: assert property (
    $rose(audible_alarm) |-> report_valid && report.intrusion)
    else $error("alarm without intrusion report");
  a_alarm_length: assert property (
    $fell(audible_alarm) |-> on_q >= ALARM_LOW)
    else $error("alarm too short");
  a_alarm_closed: assert property (
    $fell(audible_alarm) |-> !front_open_pin)
    else $error("alarm cleared with door open");
  a_auth_quiet: assert property (
    report_valid && report == 4'h3 |-> !audible_alarm)
    else $error("alarm after shunt");
  a_intr_sounds: assert property (
    report_valid && report.interior && report.intrusion |-> audible_alarm)
    else $error("interior intrusion silent");
  a_report_pulse: assert property (
    report_valid ##1 report_valid |=> !report_valid)
    else $error("report valid too long");
  a_report_holds: assert property (
    $changed(report) |-> report_valid)
    else $error("report changed without valid");
  a_fare_oos: assert property (
    psel && penable && pwrite && paddr == CTRL_OFS |-> ##2 fare_enable == !$past(pwdata[16], 2))
    else $error("fare enable not following oos");
  a_err_unmapped: assert property (
    psel && penable && paddr > EVENT_OFS |-> pready && pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");

  c_intrusion: cover property (report_valid && report == 4'h4);
  c_int_auth: cover property (report_valid && report == 4'hB);
  c_int_unauth: cover property (report_valid && report == 4'hC);
endmodule

// ==== sim/dim_rcc_model.sv ====
// Remote centre stand-in: counts each report the monitor sends and keeps the last one.
// Assumes report is meaningful only while report_valid is high.
`timescale 1ns/100ps
module dim_rcc_model (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 report_valid,
  input  wire dim_pkg::dim_report_t report,
  output int                        rep_count,
  output dim_pkg::dim_report_t      last_rep
);
  import dim_pkg::*;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rep_count <= 0;
      last_rep  <= '0;
    end else if (report_valid) begin
      rep_count <= rep_count + 1;
      last_rep  <= report;
    end
  end
endmodule

// ==== sim/door_intrusion_monitor_tb.sv ====
// Self-checking bench for dim_top with a short tick and a remote centre model.
// Assumes the checker file and dim_rcc_model are compiled first.
`timescale 1ns/100ps
module door_intrusion_monitor_tb;
  import dim_pkg::*;
  localparam int unsigned TICK = 4;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [5:0]  pins    = 6'h00;
  logic [31:0] lfsr_q  = 32'h01D989FE;
  logic [31:0] prdata;
  logic        pready, pslverr, audible_alarm, fare_enable, report_valid, irq;
  dim_report_t report, last_rep;
  dim_report_t exp_q[$];
  int          err_count = 0;
  int          tests_run = 0;
  int          rep_count;
  int          entry;

  always #10 sys_clk = ~sys_clk;

  dim_top #(.TICK_CYCLES(TICK)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .front_open_pin(pins[PIN_FRONT]),
    .shunt_key_pin(pins[PIN_SHUNT]), .lock_release_pin(pins[PIN_LOCK]),
    .latch_retract_pin(pins[PIN_LATCH]), .interior_open_pin(pins[PIN_INT]),
    .keypad_code_pin(pins[PIN_KEYPAD]), .audible_alarm(audible_alarm),
    .fare_enable(fare_enable), .report_valid(report_valid), .report(report), .irq(irq));

  dim_rcc_model rcc (.sys_clk(sys_clk), .resetn(resetn), .report_valid(report_valid),
    .report(report), .rep_count(rep_count), .last_rep(last_rep));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    if (!wr) chk(prdata, exp, "read data");
    chk(32'(pslverr), 32'(err), "slave error");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_pin(input int b, input logic v);
    @(posedge sys_clk);
    pins[b] <= v;
  endtask

  // Pins pass a two-flop sync, so pulses last six clocks
  task automatic pulse(input int b);
    set_pin(b, 1'b1);
    cyc(6);
    pins[b] <= 1'b0;
    cyc(6);
  endtask

  task automatic wait_alarm(input logic v, input int n);
    int i;
    for (i = 0; i < n && audible_alarm !== v; i++) @(posedge sys_clk);
    chk(32'(audible_alarm), 32'(v), "alarm level");
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always @(posedge sys_clk) begin
    if (report_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'(report), 32'hFF, "unexpected report");
      else chk(32'(report), 32'(exp_q.pop_front()), "report code");
    end
  end

  // Whole sequence needs about 750 clocks
  initial begin
    cyc(5000);
    err_count++;
    close_out();
  end

  initial begin
    cyc(2);
    resetn <= 1'b1;
    cyc(1);
    chk(32'(fare_enable), 32'h1, "fare enable at reset");
    apb(1'b0, CTRL_OFS, 32'h0, 32'h00001E0F, 1'b0);
    apb(1'b0, IRQ_MASK_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 12'h020, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 12'h020, 32'hFFFFFFFF, 32'h0, 1'b1);
    lfsr_q = lfsr_next(lfsr_q);
    entry = 15 + int'(lfsr_q[3:0]);
    apb(1'b1, CTRL_OFS, 32'h00001E00 | 32'(entry), 32'h0, 1'b0);
    apb(1'b1, IRQ_MASK_OFS, 32'h0000000F, 32'h0, 1'b0);
    exp_q.push_back(4'h4);
    set_pin(PIN_FRONT, 1'b1);
    cyc((entry - 1) * TICK);
    chk(32'(audible_alarm), 32'h0, "alarm in entry delay");
    wait_alarm(1'b1, 3 * TICK + 8);
    cyc(2);
    chk(32'(irq), 32'h1, "irq on intrusion");
    set_pin(PIN_FRONT, 1'b0);
    cyc(25 * TICK);
    chk(32'(audible_alarm), 32'h1, "alarm held");
    wait_alarm(1'b0, 8 * TICK);
    apb(1'b0, EVENT_OFS, 32'h0, 32'h00000102, 1'b0);
    apb(1'b1, IRQ_STAT_OFS, 32'h00000002, 32'h0, 1'b0);
    cyc(2);
    chk(32'(irq), 32'h0, "irq cleared");
    pulse(PIN_LOCK);
    pulse(PIN_LATCH);
    set_pin(PIN_FRONT, 1'b1);
    cyc(8);
    exp_q.push_back(4'h3);
    pulse(PIN_SHUNT);
    pulse(PIN_KEYPAD);
    exp_q.push_back(4'hB);
    set_pin(PIN_INT, 1'b1);
    cyc(40 * TICK);
    chk(32'(audible_alarm), 32'h0, "shunted access quiet");
    apb(1'b0, IRQ_STAT_OFS, 32'h0, 32'h00000005, 1'b0);
    set_pin(PIN_INT, 1'b0);
    set_pin(PIN_FRONT, 1'b0);
    cyc(8);
    apb(1'b1, IRQ_STAT_OFS, 32'h0000000F, 32'h0, 1'b0);
    apb(1'b1, IRQ_MASK_OFS, 32'h0, 32'h0, 1'b0);
    set_pin(PIN_FRONT, 1'b1);
    cyc(8);
    exp_q.push_back(4'h3);
    pulse(PIN_SHUNT);
    exp_q.push_back(4'hC);
    set_pin(PIN_INT, 1'b1);
    wait_alarm(1'b1, 16);
    cyc(2);
    chk(32'(irq), 32'h0, "masked irq");
    apb(1'b1, IRQ_MASK_OFS, 32'h00000008, 32'h0, 1'b0);
    cyc(2);
    chk(32'(irq), 32'h1, "unmasked irq");
    set_pin(PIN_INT, 1'b0);
    set_pin(PIN_FRONT, 1'b0);
    wait_alarm(1'b0, 40 * TICK);
    apb(1'b1, IRQ_STAT_OFS, 32'h0000000F, 32'h0, 1'b0);
    cyc(2);
    chk(32'(irq), 32'h0, "irq cleared");
    apb(1'b1, CTRL_OFS, 32'h00011E0F, 32'h0, 1'b0);
    cyc(3);
    chk(32'(fare_enable), 32'h0, "fare stopped");
    apb(1'b1, CTRL_OFS, 32'h00001E0F, 32'h0, 1'b0);
    cyc(3);
    chk(32'(fare_enable), 32'h1, "fare resumed");
    // Closed inside the delay without shunt: intrusion report, no local alarm
    exp_q.push_back(4'h4);
    set_pin(PIN_FRONT, 1'b1);
    cyc(8);
    set_pin(PIN_FRONT, 1'b0);
    cyc(8 * TICK);
    chk(32'(audible_alarm), 32'h0, "closed unshunted quiet");
    cyc(4);
    chk(32'(exp_q.size()), 32'h0, "reports missing");
    chk(32'(rep_count), 32'h6, "reports at centre");
    chk(32'(last_rep), 32'h4, "last report at centre");
    close_out();
  end
endmodule

bind dim_top dim_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .front_open_pin(front_open_pin), .interior_open_pin(interior_open_pin),
  .audible_alarm(audible_alarm), .fare_enable(fare_enable),
  .report_valid(report_valid), .report(report));
